// ### rtl/mpd_pkg.sv
// mpd_pkg: constants and types shared by the motor position logic
// assumes a single 125 mhz clock domain
package mpd_pkg;
	localparam int         COUNT_WIDTH = 8;
	localparam logic [7:0] COUNT_ZERO  = 8'h7f;   // zero shaft position, also setpoint
	localparam logic [7:0] RAMP_TOP    = 8'hff;   // ramp counter wraps after this value
	localparam logic [7:0] RAMP_START  = 8'h00;
	localparam logic [7:0] SAMPLE_INIT = 8'h00;

	// quadrature step decoded from one phase sample pair
	typedef enum logic [2:0] {
		STEP_NONE = 3'b001,
		STEP_UP   = 3'b010,
		STEP_DOWN = 3'b100
	} mpd_step_type;
endpackage

// ### rtl/mpd_quad_if.sv
// mpd_quad_if: decoded step from the quadrature decoder to the position logic
// assumes both ends share clk
`timescale 1ns/10ps
interface mpd_quad_if;
	mpd_pkg::mpd_step_type step;
	logic                  dir_ccw;

	modport decoder (output step, output dir_ccw);
	modport user    (input step, input dir_ccw);
endinterface

// ### rtl/mpd_quad_decoder.sv
// mpd_quad_decoder: clocked quadrature decoder for encoder phases a and b
// assumes phases are already synchronous to clk
`timescale 1ns/10ps
module mpd_quad_decoder (
	input  wire logic   clk,
	input  wire logic   arst_n,
	input  wire logic   phase_a,
	input  wire logic   phase_b,
	mpd_quad_if.decoder quad
);
	typedef struct packed {
		logic a;
		logic b;
	} mpd_dec_state_type;

	mpd_dec_state_type state;
	mpd_dec_state_type next_state;

	// compare previous and current phase pair; x1 decode on rising edges of a
	always_comb begin
		next_state.a = phase_a;
		next_state.b = phase_b;
		quad.step    = mpd_pkg::STEP_NONE;
		quad.dir_ccw = 1'b0;
		if (phase_a && !state.a) begin
			// b low on rising a means clockwise travel
			quad.step    = phase_b ? mpd_pkg::STEP_DOWN : mpd_pkg::STEP_UP; // R7
			quad.dir_ccw = phase_b; // R7
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
endmodule

// ### rtl/mpd_motor_position.sv
// mpd_motor_position: position count, pwm from a digitised correction, zero blanking
// assumes encoder phases and correction sample synchronous to clk
// assumes the encoder holds phase a low for a cycle between slots
// assumes the motor driver reads speed and direction as plain levels
//
// Summary of operation
// R1: an 8-bit up/down count tracks encoder slots, up clockwise and down counter-clockwise.
// R2: the count starts at 127, the zero position and loop setpoint.
// R3: when bits 0 to 6 are high and the top bit is low the speed output is held low.
// R4: at any other count the pwm output passes to the speed output unchanged.
// R5: direction output from the direction flip-flop is low clockwise, high counter-clockwise.
// R6: the 8-bit correction sample is compared against the ramp counter to form the duty.
// R7: both encoder phases feed direction detection and the clocked quadrature decoder.
// R8: zero blanking is decided from the current count every cycle.
`timescale 1ns/10ps
module mpd_motor_position (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// encoder phases
	input  wire logic       phase_a,
	input  wire logic       phase_b,
	// digitised correction from the analog loop
	input  wire logic [7:0] correction_sample,
	// motor driver side, and the position count for the outer loop
	output logic            motor_speed,
	output logic            direction,
	output logic [7:0]      position_count
);
	// all state of the block, grouped by function
	typedef struct packed {
		// shaft position in encoder slots
		logic [7:0] count;
		// pwm generator
		logic [7:0] ramp_counter;
		logic [7:0] sample;
		logic       pwm;
		// drive direction held between steps
		logic       direction_flip_flop;
	} mpd_state_type;

	// registered state and its next value
	mpd_state_type state;
	mpd_state_type next_state;
	logic          at_zero;
	logic          count_top_bit;
	// helper values built from the state and the decoded step
	logic          step_seen;      // decoder reported a rising edge of phase a
	logic          ramp_wrap;      // ramp at the last value of its period
	logic [7:0]    next_count;     // count after the decoded step
	logic          next_direction; // direction flip-flop input
	logic [7:0]    next_ramp;      // ramp counter input
	logic [7:0]    next_sample;    // held correction sample input
	logic          next_pwm;       // comparator result for the next cycle

	// one step of the count; wraps at 8 bits as a plain binary counter would,
	// so an overrun folds around instead of sticking at an end stop
	function automatic logic [7:0] count_after(
		input logic [7:0]            count,
		input mpd_pkg::mpd_step_type step
	);
		logic [7:0] result;
		unique case (step)
			mpd_pkg::STEP_UP:   result = count + 8'h01; // R1
			mpd_pkg::STEP_DOWN: result = count - 8'h01; // R1
			mpd_pkg::STEP_NONE: result = count;
			default:            result = count;
		endcase
		return result;
	endfunction

	// any decoded step, in either direction;
	// a falling edge of phase a never counts
	function automatic logic step_moves(
		input mpd_pkg::mpd_step_type step
	);
		return step != mpd_pkg::STEP_NONE;
	endfunction

	// zero position: low bits all high, top bit low; no pipeline delay
	function automatic logic is_zero_position(
		input logic [6:0] low_bits,
		input logic       top_bit
	);
		return (&low_bits) && !top_bit; // R3 R8
	endfunction

	// ramp has reached the last value of its period;
	// shared by the ramp itself and the sample latch
	function automatic logic ramp_at_top(
		input logic [7:0] ramp
	);
		return ramp == mpd_pkg::RAMP_TOP;
	endfunction

	// free-running ramp, back to the start value after the top;
	// the period stays 256 cycles whatever the sample
	function automatic logic [7:0] ramp_after(
		input logic [7:0] ramp
	);
		logic [7:0] result;
		if (ramp_at_top(ramp)) begin
			result = mpd_pkg::RAMP_START;
		end else begin
			result = ramp + 8'h01;
		end
		return result;
	endfunction

	// sample taken only at the wrap, so a duty change never splits a period
	function automatic logic [7:0] sample_after(
		input logic [7:0] held,
		input logic [7:0] fresh,
		input logic       wrap
	);
		logic [7:0] result;
		if (wrap) begin
			result = fresh; // R6
		end else begin
			result = held;
		end
		return result;
	endfunction

	// direction only moves on a step, so it holds while the shaft rests
	function automatic logic direction_after(
		input logic held,
		input logic ccw,
		input logic moved
	);
		logic result;
		if (moved) begin
			result = ccw; // R5 R7
		end else begin
			result = held;
		end
		return result;
	endfunction

	// comparator: high while the sample exceeds the ramp, duty is sample/256;
	// a sample of 255 therefore never reaches a full duty
	function automatic logic pwm_level(
		input logic [7:0] sample,
		input logic [7:0] ramp
	);
		return sample > ramp; // R6
	endfunction

	// blanking mux; the zero position wins over any duty so the motor rests
	function automatic logic gate_speed(
		input logic pwm,
		input logic blank
	);
		logic result;
		if (blank) begin
			result = 1'b0; // R3
		end else begin
			result = pwm; // R4
		end
		return result;
	endfunction

	// decoded step travels in the quadrature interface
	mpd_quad_if quad ();

	// x1 decoder on the encoder phases
	mpd_quad_decoder u_decoder (
		.clk     (clk),
		.arst_n  (arst_n),
		.phase_a (phase_a),
		.phase_b (phase_b),
		.quad    (quad.decoder)
	);

	// zero detect from the live count, no pipeline delay
	assign count_top_bit = state.count[mpd_pkg::COUNT_WIDTH-1];
	assign at_zero       = is_zero_position(state.count[mpd_pkg::COUNT_WIDTH-2:0],
	                                        count_top_bit); // R3 R8

	// step decode shared by the count and the direction flip-flop
	assign step_seen      = step_moves(quad.step);
	assign next_count     = count_after(state.count, quad.step); // R1
	assign next_direction = direction_after(state.direction_flip_flop,
	                                        quad.dir_ccw,
	                                        step_seen); // R5 R7

	// ramp and comparator; the compare uses the registered sample only
	assign ramp_wrap   = ramp_at_top(state.ramp_counter);
	assign next_ramp   = ramp_after(state.ramp_counter);
	assign next_sample = sample_after(state.sample, correction_sample, ramp_wrap); // R6
	assign next_pwm    = pwm_level(state.sample, state.ramp_counter); // R6

	// every register input comes from the helpers above
	always_comb begin
		next_state                     = state;
		next_state.count               = next_count; // R1
		next_state.direction_flip_flop = next_direction; // R5
		next_state.ramp_counter        = next_ramp;
		next_state.sample              = next_sample; // R6
		next_state.pwm                 = next_pwm; // R6
	end

	// reset puts the shaft at zero with the motor stopped
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			// constants only, so reset never depends on other logic
			state.count               <= mpd_pkg::COUNT_ZERO; // R2
			state.ramp_counter        <= mpd_pkg::RAMP_START;
			state.sample              <= mpd_pkg::SAMPLE_INIT;
			state.pwm                 <= 1'b0;
			state.direction_flip_flop <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// blanking mux on the registered pwm, so the zero stop needs no extra cycle
	assign motor_speed    = gate_speed(state.pwm, at_zero); // R3 R4
	// direction pin straight from the direction flip-flop
	assign direction      = state.direction_flip_flop; // R5
	// position count for the outer loop, straight from the counter
	assign position_count = state.count;
endmodule

// ### sim/mpd_motor_position_assertions.sv
// port assertions for mpd_motor_position; assumes one clock domain
`timescale 1ns/10ps
module mpd_chk (
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic       phase_a,
	input wire logic       phase_b,
	input wire logic       motor_speed,
	input wire logic       direction,
	input wire logic [7:0] position_count
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence s_cw; $rose(phase_a) && !phase_b; endsequence
	sequence s_ccw; $rose(phase_a) && phase_b; endsequence
	property p_up; s_cw |=> position_count == $past(position_count) + 8'h01; endproperty
	a_up: assert property (p_up) else $error("no up step");
	property p_dn; s_ccw |=> position_count == $past(position_count) - 8'h01; endproperty
	a_dn: assert property (p_dn) else $error("no down step");
	property p_dir; $rose(phase_a) |=> direction == $past(phase_b); endproperty
	a_dir: assert property (p_dir) else $error("wrong direction");
	property p_zero; position_count == mpd_pkg::COUNT_ZERO |-> !motor_speed; endproperty
	a_zero: assert property (p_zero) else $error("not blanked");
	property p_hold; !$rose(phase_a) |=> $stable(position_count); endproperty
	a_hold: assert property (p_hold) else $error("count moved");
	property p_dhold; !$rose(phase_a) |=> $stable(direction); endproperty
	a_dhold: assert property (p_dhold) else $error("direction moved");
	property p_once; s_cw |=> $changed(position_count) ##1 $stable(position_count); endproperty
	a_once: assert property (p_once) else $error("double step");
	property p_fall; $fell(phase_a) |=> $stable(position_count); endproperty
	a_fall: assert property (p_fall) else $error("falling edge stepped");
	property p_rst; $rose(arst_n) |-> position_count == mpd_pkg::COUNT_ZERO; endproperty
	a_rst: assert property (p_rst) else $error("count not at zero after reset");
endmodule
bind mpd_motor_position mpd_chk chk_u (.clk, .arst_n, .phase_a, .phase_b, .motor_speed,
	.direction, .position_count);

// ### sim/mpd_enc.sv
// encoder model; phases move on falling clk, b settles before a rises
`timescale 1ns/10ps
module mpd_enc (
	input wire logic clk,
	output logic     phase_a,
	output logic     phase_b
);
	initial {phase_a, phase_b} = 2'b00;
	// gap stretches both halves, so prompt and slow shafts both occur
	task step(logic ccw, int gap);
		@(negedge clk) phase_b = ccw;
		@(negedge clk) phase_a = 1'b1;
		#(8 * gap + 8) phase_a = 1'b0;
		#(8 * gap + 8);
	endtask
endmodule

// ### sim/motor_position_pwm_direction_bench.sv
// random walk bench; the encoder model moves the phases
`timescale 1ns/10ps
module motor_position_pwm_direction_bench;
	logic       clk = 1'b0, arst_n = 1'b0, d, pa, pb, spd, dir;
	logic [7:0] smp = 8'h00, e = 8'h7f, cnt;
	logic [8:0] hi;
	int         n_errors = 0, tests_run = 0;
	always #4 clk = ~clk;
	mpd_enc enc_u (.clk(clk), .phase_a(pa), .phase_b(pb));
	mpd_motor_position dut_u (.clk(clk), .arst_n(arst_n), .phase_a(pa), .phase_b(pb),
		.correction_sample(smp), .motor_speed(spd), .direction(dir), .position_count(cnt));
	task chk(string n, logic [8:0] x, logic [8:0] g);
		tests_run++;
		if (g !== x) $display("[FAIL] %s exp %h got %h", n, x, g);
		n_errors += int'(g !== x);
	endtask
	task give_verdict;
		if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#400000 n_errors++;
		give_verdict;
	end
	// expected count after one slot, wrapping at 8 bits
	function automatic logic [7:0] exp_count(logic [7:0] c, logic ccw);
		return ccw ? c - 8'h01 : c + 8'h01;
	endfunction
	// expected high cycles in one ramp period; none at the zero position
	function automatic logic [8:0] exp_duty(logic [7:0] c, logic [7:0] s);
		return (c == mpd_pkg::COUNT_ZERO) ? 9'h000 : {1'b0, s};
	endfunction
	// up, then down through zero and the wrap, then random with a mid-run reset
	initial begin
		void'($urandom(32'h6bff2c03));
		repeat (2) @(negedge clk);
		arst_n = 1'b1;
		for (int i = 0; i < 300; i++) begin
			d = (i < 4) ? 1'b0 : (i < 140) ? 1'b1 : 1'($urandom);
			enc_u.step(d, $urandom % 3);
			e = exp_count(e, d);
			chk("step", {d, e}, {dir, cnt});
			if (i == 150) begin
				@(negedge clk) arst_n = 1'b0;
				repeat (2) @(negedge clk);
				arst_n = 1'b1;
				e = mpd_pkg::COUNT_ZERO;
				chk("reset", {1'b0, e}, {dir, cnt});
			end
			if (i % 100 == 3 || i == 150) begin
				smp = (i == 3) ? 8'hff : (i == 103) ? 8'h00 :
				      (i == 150) ? 8'h80 : 8'($urandom);
				hi = 9'h000;
				repeat (520) @(negedge clk);
				repeat (256) @(negedge clk) hi += spd;
				chk("duty", exp_duty(e, smp), hi);
			end
		end
		give_verdict;
	end
endmodule
